// ### fbrc_ctrl.sv
// fbrc_ctrl.sv: host controller for an asynchronous parallel NOR flash
// assumes flash pins wired by the bench; two-way data split in three
`default_nettype none
`include "fbrc_defs.svh"

// Operation
// R1: hold reset low 25 us busy, 100 ns idle
// R2: device finishes reset within 100 ns
// R3: wait wake delay after reset and ready
// R4: read: enabled, output enable low, write high
// R5: device enabled by select pin truth table
// R6: never assert output enable with strobe
// R7: narrow select low uses low byte only
// R8: low supply blocks alteration, reads allowed
// R9: busy pin low while algorithm runs
// R10: write: enabled, output high, strobe low
// R11: reset leaves four-word page mode
// R12: eight-word mode selects word by bits 3:1
// R13: four-word mode selects word by bits 2:1
// R14: first access slow, page hits fast
// R15: select toggle or page change reloads buffer
// R16: issue read-array before array page reads
// R17: register reads load single word only
// R18: page configuration resets with reset pin
// R19: configuration: two writes, value on address
// R20: bit 13 selects eight-word page length
// R21: write zeros to reserved configuration bits
// R22: eight-word mode needs clear-status afterwards
// R23: reset leaves read-array, status 0080h
// R24: device latches on strobe rising edge
module fbrc_ctrl #(
  parameter int AW        = 24,                        // flash address width
  parameter int RST_LONG  = `FBRC_CYC(`FBRC_RST_LONG_NS) // long reset cycles
) (
  input  wire logic          CLOCK,    // 200 MHz clock
  input  wire logic          RST_B,    // synchronous reset, active low
  input  wire logic          REQ,      // request valid
  input  wire logic          REQ_WR,   // 1 write, 0 read
  input  wire logic          REQ_LONG, // assume algorithm may be running
  input  wire logic          REQ_CFG,  // write page configuration
  input  wire logic          REQ_RST,  // pulse reset pin
  input  wire logic [AW-1:0] REQ_ADDR, // address
  input  wire logic [15:0]   REQ_DATA, // write data or config value
  input  wire logic          NARROW,   // 1 selects eight-bit bus
  output logic               READY,    // controller can take a request
  output logic               RSP_VALID,// read data valid, one cycle
  output logic [15:0]        RSP_DATA, // read data
  output logic               EIGHT_WORD,// page length last written, or four-word after a reset
  output logic               BUSY,     // flash algorithm running
  output logic               FL_RST_N, // power_down_reset_n
  output logic               FL_CS_A,  // chip_select_a
  output logic               FL_CS_B,  // chip_select_b
  output logic               FL_CS_C,  // chip_select_c
  output logic               FL_OE_N,  // output_enable_n
  output logic               FL_WE_N,  // write_strobe_n
  output logic               FL_NARROW_N,// narrow_bus_sel_n
  output logic [AW-1:0]      FL_ADDR,  // address pins
  output logic [15:0]        FL_DQ_O,  // data out
  output logic               FL_DQ_OE, // data drive enable
  input  wire logic [15:0]   FL_DQ_I,  // data in
  input  wire logic          FL_BUSY_I // busy_status_pin, pulled up
);

  localparam int TW = 14;
  localparam logic [TW-1:0] C_LONG  = TW'(RST_LONG);
  localparam logic [TW-1:0] C_SHORT = TW'(`FBRC_CYC(`FBRC_RST_SHORT_NS));
  localparam logic [TW-1:0] C_WAKE  = TW'(`FBRC_CYC(`FBRC_WAKE_NS));
  localparam logic [TW-1:0] C_ACC   = TW'(`FBRC_CYC(`FBRC_ACC_NS));
  localparam logic [TW-1:0] C_PAGE  = TW'(`FBRC_CYC(`FBRC_PAGE_NS));
  localparam logic [TW-1:0] C_WP    = TW'(`FBRC_CYC(`FBRC_WP_NS));
  localparam logic [TW-1:0] C_WPH   = TW'(`FBRC_CYC(`FBRC_WPH_NS));

  // whole controller state
  typedef struct packed {
    fbrc_pkg::fbrc_state_t st;     // sequencer
    fbrc_pkg::fbrc_pins_t  pin;    // registered pins
    logic [1:0]            wseq;   // remaining writes of a sequence
    logic [AW-1:0]         sel;    // upper address of open page
    logic                  open;   // page buffer holds valid page
    logic                  eight;  // eight-word page mode shadow
    logic                  rvalid; // response pulse
    logic [15:0]           rdata;  // response data
    logic [2:0]            bsync;  // busy pin synchroniser
    logic                  busy;   // filtered busy level
    logic                  armed;  // reset pulse timer has been loaded
  } fbrc_st_t;

  fbrc_st_t    s;
  fbrc_st_t    next_s;
  logic        t_load;   // timer load strobe
  logic [TW-1:0] t_val;  // timer load value
  logic        t_done;   // timer expired

  // phase timer
  fbrc_timer #(.W(TW)) u_timer (
    .CLOCK (CLOCK),
    .RST_B (RST_B),
    .LOAD  (t_load),
    .VALUE (t_val),
    .DONE  (t_done)
  );

  // page offset mask for the current page length
  function automatic logic [AW-1:0] page_hi(input logic [AW-1:0] a,
                                            input logic e);
    page_hi = e ? {a[AW-1:4], 4'h0} : {a[AW-1:3], 3'h0}; // R12 R13 R15
  endfunction

  // sequencer and pin drive
  always_comb begin
    next_s = s;
    next_s.rvalid = 1'b0;
    t_load = 1'b0;
    t_val  = '0;
    // three-stage sync, change counted when stages two and three agree
    next_s.bsync = {s.bsync[1:0], FL_BUSY_I};
    if (s.bsync[2] == s.bsync[1]) begin
      next_s.busy = ~s.bsync[2]; // R9
    end
    case (s.st)
      fbrc_pkg::FBRC_RESET: begin
        // reset pin low; released when timer ends
        next_s.pin.reset_n = 1'b0;
        next_s.pin.dout_en = 1'b0;
        if (!s.armed) begin
          // entered from the reset input: timer is still zero, load it
          next_s.armed = 1'b1;
          t_load = 1'b1; // R1
          t_val  = C_LONG;
        end else if (t_done) begin
          next_s.armed = 1'b0;
          next_s.pin.reset_n = 1'b1; // R1
          next_s.eight = 1'b0; // R11 R18
          next_s.open  = 1'b0;
          t_load = 1'b1;
          t_val  = C_WAKE;
          next_s.st = fbrc_pkg::FBRC_WAKE;
        end
      end
      fbrc_pkg::FBRC_WAKE: begin
        // wait from the later of release and ready
        if (s.busy) begin
          t_load = 1'b1; // R3
          t_val  = C_WAKE;
        end else if (t_done) begin
          next_s.st = fbrc_pkg::FBRC_IDLE; // R3
        end
      end
      fbrc_pkg::FBRC_IDLE: begin
        next_s.pin.oe_n = 1'b1;
        next_s.pin.we_n = 1'b1;
        next_s.pin.dout_en = 1'b0;
        next_s.pin.narrow_n = ~NARROW; // R7
        if (s.wseq != 2'd0) begin
          // confirm write of configuration: value on address again
          next_s.wseq = s.wseq - 2'd1;
          next_s.pin.cs_a = 1'b0;
          // eight-word mode ends with a clear-status write
          if (s.wseq == 2'd1 && s.eight) begin
            next_s.pin.dout = `FBRC_CMD_CLR_STATUS; // R22
          end else begin
            next_s.pin.dout = `FBRC_CMD_CFG_CONFIRM; // R19
          end
          next_s.pin.dout_en = 1'b1;
          next_s.pin.we_n = 1'b0; // R10
          next_s.open = 1'b0;
          t_load = 1'b1;
          t_val  = C_WP;
          next_s.st = fbrc_pkg::FBRC_WR_LO;
        end else if (REQ && REQ_RST) begin
          next_s.pin.cs_a = 1'b1;
          next_s.pin.reset_n = 1'b0;
          next_s.armed = 1'b1; // timer loaded here already
          t_load = 1'b1;
          t_val  = REQ_LONG ? C_LONG : C_SHORT; // R1
          next_s.st = fbrc_pkg::FBRC_RESET;
        end else if (REQ && (REQ_WR || REQ_CFG)) begin
          next_s.pin.cs_a = 1'b0; // R5
          if (REQ_CFG) begin
            // value on address with reserved bits forced to zero
            next_s.pin.addr = '0;
            next_s.pin.addr[`FBRC_CFG_PAGE_BIT] =
              REQ_DATA[`FBRC_CFG_PAGE_BIT]; // R21
            next_s.pin.dout = `FBRC_CMD_CFG_SETUP; // R19
            next_s.eight = REQ_DATA[`FBRC_CFG_PAGE_BIT]; // R20
            next_s.wseq = REQ_DATA[`FBRC_CFG_PAGE_BIT] ? 2'd2 : 2'd1;
          end else begin
            next_s.pin.addr = REQ_ADDR;
            next_s.pin.dout = REQ_DATA;
          end
          next_s.pin.dout_en = 1'b1;
          next_s.pin.we_n = 1'b0; // R6 R10
          next_s.open = 1'b0; // R16
          t_load = 1'b1;
          t_val  = C_WP;
          next_s.st = fbrc_pkg::FBRC_WR_LO;
        end else if (REQ) begin
          next_s.pin.cs_a = 1'b0;
          next_s.pin.addr = REQ_ADDR;
          next_s.pin.oe_n = 1'b0; // R4 R6
          t_load = 1'b1;
          // page hit only when select stayed low and page unchanged
          t_val = (s.open && !s.pin.cs_a &&
                   page_hi(REQ_ADDR, s.eight) == s.sel) ? C_PAGE
                                                        : C_ACC; // R14 R15
          next_s.sel  = page_hi(REQ_ADDR, s.eight);
          next_s.open = 1'b1;
          next_s.st = fbrc_pkg::FBRC_RD;
        end else begin
          // deselect when idle: toggles select, next read is slow
          next_s.pin.cs_a = 1'b1; // R15
          next_s.open = 1'b0;
        end
      end
      fbrc_pkg::FBRC_RD: begin
        if (t_done) begin
          next_s.rvalid = 1'b1;
          next_s.rdata = s.pin.narrow_n ? FL_DQ_I
                                        : {8'h00, FL_DQ_I[7:0]}; // R7
          next_s.pin.oe_n = 1'b1;
          next_s.st = fbrc_pkg::FBRC_IDLE;
        end
      end
      fbrc_pkg::FBRC_WR_LO: begin
        if (t_done) begin
          next_s.pin.we_n = 1'b1; // R24
          t_load = 1'b1;
          t_val  = C_WPH;
          next_s.st = fbrc_pkg::FBRC_WR_HI;
        end
      end
      fbrc_pkg::FBRC_WR_HI: begin
        if (t_done) begin
          next_s.pin.dout_en = 1'b0;
          next_s.st = fbrc_pkg::FBRC_IDLE;
        end
      end
      default: begin
        next_s.st = fbrc_pkg::FBRC_IDLE;
      end
    endcase
  end

  // register the state; reset starts a long reset pulse
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      s <= '0;
      s.st <= fbrc_pkg::FBRC_RESET;
      s.pin.cs_a <= 1'b1;
      s.pin.oe_n <= 1'b1;
      s.pin.we_n <= 1'b1;
      s.pin.narrow_n <= 1'b1;
      s.bsync <= 3'h7;
    end else begin
      s <= next_s;
    end
  end

  assign READY       = (s.st == fbrc_pkg::FBRC_IDLE) && (s.wseq == 2'd0);
  assign RSP_VALID   = s.rvalid;
  assign RSP_DATA    = s.rdata;
  assign EIGHT_WORD  = s.eight;
  assign BUSY        = s.busy;
  assign FL_RST_N    = s.pin.reset_n;
  assign FL_CS_A     = s.pin.cs_a;
  assign FL_CS_B     = s.pin.cs_b;
  assign FL_CS_C     = s.pin.cs_c;
  assign FL_OE_N     = s.pin.oe_n;
  assign FL_WE_N     = s.pin.we_n;
  assign FL_NARROW_N = s.pin.narrow_n;
  assign FL_ADDR     = s.pin.addr;
  assign FL_DQ_O     = s.pin.dout;
  assign FL_DQ_OE    = s.pin.dout_en;

endmodule

`default_nettype wire

// ### fbrc_defs.svh
// fbrc_defs.svh: constants for the parallel flash bus controller
// assumes a 200 MHz controller clock; included by bare name
`ifndef FBRC_DEFS_SVH
`define FBRC_DEFS_SVH

`define FBRC_CLK_PS          5000
// reset low time while an algorithm may run, in ns
`define FBRC_RST_LONG_NS     25000
// reset low time when the flash is idle, in ns
`define FBRC_RST_SHORT_NS    100
// wake delay after reset release before reads, in ns (plain default)
`define FBRC_WAKE_NS         210
// access time of a first read, in ns (plain default)
`define FBRC_ACC_NS          75
// access time of a page hit, in ns (plain default)
`define FBRC_PAGE_NS         25
// write pulse low and high widths, in ns (plain default)
`define FBRC_WP_NS           60
`define FBRC_WPH_NS          35
// least times round up to whole cycles
`define FBRC_CYC(ns) (((ns) * 1000 + `FBRC_CLK_PS - 1) / `FBRC_CLK_PS)

// command codes
`define FBRC_CMD_CFG_SETUP   16'h0060
`define FBRC_CMD_CFG_CONFIRM 16'h0004
`define FBRC_CMD_CLR_STATUS  16'h0050
`define FBRC_CMD_READ_ARRAY  16'h00FF
// page length field of the page configuration value
`define FBRC_CFG_PAGE_BIT    13
`define FBRC_CFG_RESET       16'h0000

`endif

// ### fbrc_pkg.sv
// fbrc_pkg.sv: types for the parallel flash bus controller
// assumes nothing beyond the constants header
`default_nettype none

package fbrc_pkg;

  // controller states
  typedef enum logic [3:0] {
    FBRC_RESET = 4'b0000,
    FBRC_WAKE  = 4'b0001,
    FBRC_IDLE  = 4'b0010,
    FBRC_RD    = 4'b0011,
    FBRC_WR_LO = 4'b0100,
    FBRC_WR_HI = 4'b0101
  } fbrc_state_t;

  // pins toward the flash, all outputs of the controller
  typedef struct packed {
    logic        reset_n;  // power_down_reset_n
    logic        cs_a;     // chip_select_a
    logic        cs_b;     // chip_select_b
    logic        cs_c;     // chip_select_c
    logic        oe_n;     // output enable
    logic        we_n;     // write strobe
    logic        narrow_n; // narrow_bus_sel_n
    logic [23:0] addr;     // address
    logic [15:0] dout;     // data toward flash
    logic        dout_en;  // high while the controller drives data
  } fbrc_pins_t;

endpackage

`default_nettype wire

// ### fbrc_timer.sv
// fbrc_timer.sv: reloadable down counter for bus phase timing
// assumes one clock domain and a synchronous active-low reset
`default_nettype none

module fbrc_timer #(
  parameter int W = 14
) (
  input  wire logic         CLOCK, // controller clock
  input  wire logic         RST_B, // synchronous reset, active low
  input  wire logic         LOAD,  // one-cycle load request
  input  wire logic [W-1:0] VALUE, // cycles to count
  output logic              DONE   // high while the count is zero
);

  // counter state
  typedef struct packed {
    logic [W-1:0] count; // remaining cycles
  } fbrc_timer_st_t;

  fbrc_timer_st_t st;
  fbrc_timer_st_t next_st;

  // next count: load wins, else count down to zero
  always_comb begin
    next_st = st;
    if (LOAD) begin
      next_st.count = VALUE;
    end else if (st.count != '0) begin
      next_st.count = st.count - 1'b1;
    end
  end

  // register the state
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign DONE = (st.count == '0);

endmodule

`default_nettype wire

// ### fbrc_monitor.sv
// fbrc_monitor.sv: port assertions for the parallel flash controller
// assumes a bind onto fbrc_ctrl and one clock domain
`default_nettype none
module fbrc_monitor (
  input wire logic        CLOCK,       // clock
  input wire logic        RST_B,       // reset, active low
  input wire logic        READY,       // controller can take a request
  input wire logic        RSP_VALID,   // read data pulse
  input wire logic [15:0] RSP_DATA,    // read data
  input wire logic        FL_RST_N,    // flash reset pin
  input wire logic        FL_CS_A,     // select a
  input wire logic        FL_CS_B,     // select b
  input wire logic        FL_CS_C,     // select c
  input wire logic        FL_OE_N,     // output enable
  input wire logic        FL_WE_N,     // write strobe
  input wire logic        FL_NARROW_N, // bus width select
  input wire logic        FL_DQ_OE     // data drive enable
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0] low_cnt; // cycles the reset pin has been low
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  // count reset pin low time, saturating
  always_ff @(posedge CLOCK) begin
    if (!RST_B || FL_RST_N) low_cnt <= 6'h00;
    else if (low_cnt != 6'h3F) low_cnt <= low_cnt + 6'h01;
  end
  a_no_oe_we: assert property (FL_OE_N || FL_WE_N)
    else $error("enable and strobe low together");
  a_read_qual: assert property (!FL_OE_N |-> !FL_CS_A && FL_WE_N && FL_RST_N && !FL_DQ_OE)
    else $error("read without proper qualifiers");
  a_write_qual: assert property (!FL_WE_N |-> !FL_CS_A && FL_RST_N && FL_DQ_OE)
    else $error("write without proper qualifiers");
  a_sel_tie: assert property (!FL_CS_B && !FL_CS_C)
    else $error("selects b or c not low");
  a_rst_entry: assert property ($rose(RST_B) |-> !FL_RST_N)
    else $error("reset pin not low leaving reset");
  a_rst_width: assert property ($rose(FL_RST_N) |-> low_cnt >= 6'h14)
    else $error("reset pin pulse too short");
  a_wake_quiet: assert property ($rose(FL_RST_N) |-> (FL_OE_N && !READY) [*8])
    else $error("access during wake delay");
  a_rsp_source: assert property (RSP_VALID |-> !$past(FL_OE_N))
    else $error("response without read cycle");
  a_narrow_data: assert property (RSP_VALID && !$past(FL_NARROW_N) |-> RSP_DATA[15:8] == 8'h00)
    else $error("narrow read upper byte not zero");
endmodule
bind fbrc_ctrl fbrc_monitor i_mon (.CLOCK(CLOCK), .RST_B(RST_B),
  .READY(READY), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA),
  .FL_RST_N(FL_RST_N), .FL_CS_A(FL_CS_A), .FL_CS_B(FL_CS_B),
  .FL_CS_C(FL_CS_C), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N),
  .FL_NARROW_N(FL_NARROW_N), .FL_DQ_OE(FL_DQ_OE));
`default_nettype wire

// ### fbrc_flash_model.sv
// fbrc_flash_model.sv: behavioural flash device for the bench
// assumes the bench resolves the shared data bus from the controller drive enable alone
`default_nettype none
module fbrc_flash_model (
  input  wire logic        RST_N,    // reset pin
  input  wire logic        CS_A,     // select a
  input  wire logic        CS_B,     // select b
  input  wire logic        CS_C,     // select c
  input  wire logic        OE_N,     // output enable
  input  wire logic        WE_N,     // write strobe
  input  wire logic        NARROW_N, // bus width select
  input  wire logic [23:0] ADDR,     // address pins
  input  wire logic [15:0] DQ_IN,    // resolved bus level
  output logic      [15:0] DQ_DRV,   // driven data
  output logic             BUSY_PIN  // busy pin level
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] cfg;              // page configuration value
  logic        cfg_setup = 1'b0; // setup cycle seen
  logic [15:0] last = 16'h0000;  // last word put out
  logic [15:0] word;             // addressed array word
  logic        en;               // device selected
  assign en = (!CS_A && !CS_B && !CS_C) || (CS_C && !(CS_A && CS_B));
  logic        busy_lo = 1'b0;   // reset completion in progress
  assign word = ADDR[15:0] ^ 16'h5A3C; // array words only
  assign BUSY_PIN = ~busy_lo; // pulled up when idle
  // finishing an aborted algorithm holds busy low after release
  always @(posedge RST_N) begin
    busy_lo = 1'b1;
    #81 busy_lo = 1'b0;
  end
  // remember output so a released bus shows its inverse
  always @(posedge OE_N) last <= word;
  // drive word or selected byte while read; else a stale-free pattern
  always_comb begin
    if (!(en && !OE_N && RST_N)) DQ_DRV = ~last;
    else if (!NARROW_N) DQ_DRV = {~last[15:8], ADDR[0] ? word[15:8] : word[7:0]};
    else DQ_DRV = word;
  end
  // commands latch on strobe rise; reset clears volatile state
  always @(posedge WE_N or negedge RST_N) begin
    if (!RST_N) begin
      cfg <= 16'h0000;
      cfg_setup <= 1'b0;
    end else if (en) begin // commands need no program supply
      cfg_setup <= DQ_IN == 16'h0060;
      if (cfg_setup && DQ_IN == 16'h0004) cfg <= ADDR[15:0];
    end
  end
endmodule
`default_nettype wire

// ### test_flash_bus_read_reset_control.sv
// test_flash_bus_read_reset_control.sv: self-checking bench
// assumes fbrc_ctrl, the flash model and the bound monitor
`default_nettype none
`include "fbrc_defs.svh"
module test_flash_bus_read_reset_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLOCK, RST_B, REQ, REQ_WR, REQ_LONG, REQ_CFG, REQ_RST, NARROW;
  logic [23:0] REQ_ADDR, base;
  logic [15:0] REQ_DATA, drv, bus;
  logic READY, RSP_VALID, EIGHT_WORD, BUSY, busy_pin, FL_RST_N, FL_CS_A;
  logic FL_CS_B, FL_CS_C, FL_OE_N, FL_WE_N, FL_NARROW_N, FL_DQ_OE;
  logic [15:0] RSP_DATA, FL_DQ_O;
  logic [23:0] FL_ADDR;
  logic [15:0] exp_q[$]; // expected read data, oldest first
  int seed = 88;
  int miscompares = 0;
  int num_checks = 0;
  int wait_n;                  // cycles from reset release to ready
  int cyc = 0;                 // free-running cycle count
  int rsp_t[$];                // cycle of every read response
  int hit_span = 7 * (`FBRC_CYC(`FBRC_PAGE_NS) + 2); // seven page hits
  int wake_min = 16 + `FBRC_CYC(`FBRC_WAKE_NS); // model busy plus wake
  logic [15:0] cfg_val;        // configuration value sent
  // count cycles for latency checks
  always @(posedge CLOCK) cyc++;
  assign bus = FL_DQ_OE ? FL_DQ_O : drv;
  fbrc_ctrl #(.AW(24), .RST_LONG(20)) i_dut (.CLOCK(CLOCK), .RST_B(RST_B),
    .REQ(REQ), .REQ_WR(REQ_WR), .REQ_LONG(REQ_LONG), .REQ_CFG(REQ_CFG),
    .REQ_RST(REQ_RST), .REQ_ADDR(REQ_ADDR), .REQ_DATA(REQ_DATA),
    .NARROW(NARROW), .READY(READY), .RSP_VALID(RSP_VALID),
    .RSP_DATA(RSP_DATA), .EIGHT_WORD(EIGHT_WORD), .BUSY(BUSY),
    .FL_RST_N(FL_RST_N), .FL_CS_A(FL_CS_A), .FL_CS_B(FL_CS_B),
    .FL_CS_C(FL_CS_C), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N),
    .FL_NARROW_N(FL_NARROW_N), .FL_ADDR(FL_ADDR), .FL_DQ_O(FL_DQ_O),
    .FL_DQ_OE(FL_DQ_OE), .FL_DQ_I(bus), .FL_BUSY_I(busy_pin));
  fbrc_flash_model i_flash (.RST_N(FL_RST_N), .CS_A(FL_CS_A),
    .CS_B(FL_CS_B), .CS_C(FL_CS_C), .OE_N(FL_OE_N), .WE_N(FL_WE_N),
    .NARROW_N(FL_NARROW_N), .ADDR(FL_ADDR), .DQ_IN(bus), .DQ_DRV(drv),
    .BUSY_PIN(busy_pin));
  // compare one value and count it
  task automatic check(input string what, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // wait for ready at a falling edge, then present one request
  task automatic issue(input logic wr, cfg, rst, nar,
                       input logic [23:0] a, input logic [15:0] d);
    int n;
    n = 0;
    while (READY !== 1'b1 && n < 400) begin
      @(negedge CLOCK);
      n++;
    end
    if (n == 400) miscompares++;
    {REQ_WR, REQ_CFG, REQ_RST, NARROW} = {wr, cfg, rst, nar};
    REQ_ADDR = a;
    REQ_DATA = d;
    REQ = 1'b1;
    @(negedge CLOCK);
  endtask
  // read with expectation noted for the watcher
  task automatic rd(input logic [23:0] a, input logic nar);
    logic [15:0] w;
    w = a[15:0] ^ 16'h5A3C;
    exp_q.push_back(nar ? {8'h00, a[0] ? w[15:8] : w[7:0]} : w);
    issue(1'b0, 1'b0, 1'b0, nar, a, 16'h0000);
  endtask
  // release the request and let everything settle
  task automatic drain(input string name);
    int n;
    REQ = 1'b0;
    n = 0;
    while ((exp_q.size() != 0 || READY !== 1'b1) && n < 400) begin
      @(negedge CLOCK);
      n++;
    end
    if (n == 400) miscompares++;
    $display("test %s done", name);
  endtask
  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // take each read result against the oldest note
  always @(negedge CLOCK) begin
    if (RSP_VALID === 1'b1) begin
      rsp_t.push_back(cyc);
      if (exp_q.size() == 0) miscompares++;
      else check("read data", RSP_DATA, exp_q.pop_front());
    end
  end
  initial begin
    CLOCK = 1'b0;
    forever #2.5 CLOCK = ~CLOCK;
  end
  initial begin
    repeat (20000) @(posedge CLOCK);
    miscompares++;
    complete_run();
  end
  initial begin
    {RST_B, REQ, REQ_WR, REQ_LONG, REQ_CFG, REQ_RST, NARROW} = 7'h00;
    REQ_ADDR = 24'h000000;
    REQ_DATA = 16'h0000;
    repeat (20) @(negedge CLOCK);
    RST_B = 1'b1;
    check("page mode", {15'h0000, EIGHT_WORD}, 16'h0000);
    for (int i = 0; i < 10; i++) rd(24'($random(seed)), i[0]);
    base = 24'($random(seed));
    for (int k = 0; k < 8; k++) rd(base ^ 24'(k), 1'b0);
    drain("reads");
    check("page hits", 16'(rsp_t[$] - rsp_t[$-7]), 16'(hit_span));
    issue(1'b1, 1'b0, 1'b0, 1'b0, base, 16'h00FF);
    cfg_val = 16'($random(seed)) | 16'h2000;
    issue(1'b1, 1'b1, 1'b0, 1'b0, 24'h000000, cfg_val);
    drain("config");
    check("eight word", {15'h0000, EIGHT_WORD}, 16'h0001);
    check("model config", i_flash.cfg, 16'h2000);
    for (int k = 0; k < 8; k++) rd({base[23:4], k[2:0], 1'b0}, 1'b0);
    drain("eight word reads");
    check("page hits", 16'(rsp_t[$] - rsp_t[$-7]), 16'(hit_span));
    cfg_val = 16'($random(seed)) & 16'hDFFF;
    issue(1'b1, 1'b1, 1'b0, 1'b0, 24'h000000, cfg_val);
    drain("four word config");
    check("eight word", {15'h0000, EIGHT_WORD}, 16'h0000);
    check("model config", i_flash.cfg, 16'h0000);
    for (int r = 0; r < 2; r++) begin
      issue(1'b1, 1'b1, 1'b0, 1'b0, 24'h000000, 16'h2000);
      drain("config before reset");
      REQ_LONG = r[0];
      issue(1'b0, 1'b0, 1'b1, 1'b0, 24'h000000, 16'h0000);
      REQ = 1'b0;
      @(posedge FL_RST_N);
      repeat (10) @(negedge CLOCK);
      check("busy", {15'h0000, BUSY}, 16'h0001);
      wait_n = 10;
      while (READY !== 1'b1 && wait_n < 400) begin
        @(negedge CLOCK);
        wait_n++;
      end
      check("wake wait", {15'h0000, wait_n >= wake_min &&
                          wait_n <= wake_min + 8}, 16'h0001);
      drain("reset");
      check("eight word", {15'h0000, EIGHT_WORD}, 16'h0000);
      check("model config", i_flash.cfg, 16'h0000);
      rd(base, r[0]);
      drain("after reset");
    end
    complete_run();
  end
endmodule
`default_nettype wire
